// File: nbgr_consts.svh
`ifndef NBGR_CONSTS_SVH
`define NBGR_CONSTS_SVH

// Width of the stored word and of each output bank
`define NBGR_WIDTH      9

// Bundled pin sample: {clock, clear_n, gate_n, drive_n, data[8:0]}
`define NBGR_IN_WIDTH   13
`define NBGR_IN_CLK     12
`define NBGR_IN_CLEAR_N 11
`define NBGR_IN_GATE_N  10
`define NBGR_IN_DRV_N   9
`define NBGR_IN_DATA_HI 8
`define NBGR_IN_DATA_LO 0

// Idle pin levels: clock low, clear, gate and drive released, data low
`define NBGR_IN_RST     13'h0e00

// Cleared contents of the register
`define NBGR_STORE_RST  9'h000

// Output enable pattern while the bus is released
`define NBGR_OE_OFF     9'h000

`endif

// File: nbgr_pkg.sv
`include "nbgr_consts.svh"

package nbgr_pkg;

	typedef logic [`NBGR_WIDTH-1:0]    nbgr_word_t;
	typedef logic [`NBGR_IN_WIDTH-1:0] nbgr_in_t;

endpackage

// File: nbgr_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "nbgr_consts.svh"

module nbgr_top
	import nbgr_pkg::*;
(
	input  wire logic             CLOCK,
	input  wire logic             SRST,
	input  wire logic             REGISTER_CLOCK,
	input  wire logic             REGISTER_CLEAR_N,
	input  wire logic             CAPTURE_GATE_N,
	input  wire logic             OUTPUT_DRIVE_N,
	input  wire nbgr_word_t       PARALLEL_INPUTS,
	output var  nbgr_word_t       BUS_DRIVERS,
	output var  nbgr_word_t       BUS_DRIVERS_OE
);

	// A bit moves only when the two later stages agree; otherwise it keeps its value
	function automatic nbgr_in_t filter_agree(
		input nbgr_in_t s2,
		input nbgr_in_t s3,
		input nbgr_in_t held
	);
		nbgr_in_t agree;
		agree = ~(s2 ^ s3);
		filter_agree = (agree & s3) | (~agree & held);
	endfunction

	nbgr_in_t   pin_bundle;
	nbgr_in_t   sync1_r;
	nbgr_in_t   sync2_r;
	nbgr_in_t   sync3_r;
	nbgr_in_t   filt_r;
	nbgr_in_t   filt_nxt;
	logic       clk_prev_r;
	nbgr_word_t store_r;
	nbgr_word_t store_nxt;
	nbgr_word_t oe_nxt;

	wire logic       f_clk;
	wire logic       f_clear_n;
	wire logic       f_gate_n;
	wire logic       f_drv_n;
	wire nbgr_word_t f_data;
	wire logic       clk_rise;
	wire logic       load_ok;

	// All pins share one pipeline so data keeps its alignment to the clock pin
	assign pin_bundle = {REGISTER_CLOCK, REGISTER_CLEAR_N, CAPTURE_GATE_N,
		OUTPUT_DRIVE_N, PARALLEL_INPUTS};
	assign filt_nxt   = filter_agree(sync2_r, sync3_r, filt_r);

	assign f_clk     = filt_r[`NBGR_IN_CLK];
	assign f_clear_n = filt_r[`NBGR_IN_CLEAR_N];
	assign f_gate_n  = filt_r[`NBGR_IN_GATE_N];
	assign f_drv_n   = filt_r[`NBGR_IN_DRV_N];
	assign f_data    = filt_r[`NBGR_IN_DATA_HI:`NBGR_IN_DATA_LO];

	assign clk_rise = f_clk & ~clk_prev_r;
	assign load_ok  = clk_rise & ~f_gate_n & f_clear_n;

	// Clear first, then a gated edge, else hold; the drive enable plays no part here
	assign store_nxt = !f_clear_n ? `NBGR_STORE_RST :
		load_ok ? f_data : store_r;

	assign oe_nxt = f_drv_n ? `NBGR_OE_OFF : ~`NBGR_OE_OFF;

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			sync1_r <= `NBGR_IN_RST;
			sync2_r <= `NBGR_IN_RST;
			sync3_r <= `NBGR_IN_RST;
			filt_r  <= `NBGR_IN_RST;
		end else begin
			sync1_r <= pin_bundle;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			filt_r  <= filt_nxt;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			clk_prev_r     <= 1'b0;
			store_r        <= `NBGR_STORE_RST;
			BUS_DRIVERS    <= `NBGR_STORE_RST;
			BUS_DRIVERS_OE <= `NBGR_OE_OFF;
		end else begin
			clk_prev_r     <= f_clk;
			store_r        <= store_nxt;
			// Value copy is kept beside the store so the output stays a plain flop
			BUS_DRIVERS    <= store_nxt;
			BUS_DRIVERS_OE <= oe_nxt;
		end
	end

	// Clear held on the pin long enough to pass the filter empties the outputs
	property p_pin_clear;
		@(posedge CLOCK) disable iff (SRST)
		(!REGISTER_CLEAR_N)[*6] |-> (BUS_DRIVERS == `NBGR_STORE_RST);
	endproperty
	a_pin_clear: assert property (p_pin_clear)
		else $error("pin clear did not empty the outputs");

	property p_clear_wins;
		@(posedge CLOCK) disable iff (SRST)
		(!f_clear_n && clk_rise && !f_gate_n) |=> (store_r == `NBGR_STORE_RST);
	endproperty
	a_clear_wins: assert property (p_clear_wins)
		else $error("clear lost against a gated clock edge");

	property p_load;
		@(posedge CLOCK) disable iff (SRST)
		(clk_rise && !f_gate_n && f_clear_n) |=> (store_r == $past(f_data));
	endproperty
	a_load: assert property (p_load)
		else $error("gated edge did not load the data");

	property p_gate_hold;
		@(posedge CLOCK) disable iff (SRST)
		(f_gate_n && f_clear_n) |=> $stable(store_r);
	endproperty
	a_gate_hold: assert property (p_gate_hold)
		else $error("store changed with the gate closed");

	property p_edge_only;
		@(posedge CLOCK) disable iff (SRST)
		(!clk_rise && f_clear_n) |=> $stable(store_r);
	endproperty
	a_edge_only: assert property (p_edge_only)
		else $error("store changed without a rising clock edge");

	property p_true_out;
		@(posedge CLOCK) disable iff (SRST)
		(clk_rise && !f_gate_n && f_clear_n) |=> (BUS_DRIVERS == $past(f_data));
	endproperty
	a_true_out: assert property (p_true_out)
		else $error("output not equal to the loaded data");

	property p_drive_on;
		@(posedge CLOCK) disable iff (SRST)
		!f_drv_n |=> (BUS_DRIVERS_OE == ~`NBGR_OE_OFF);
	endproperty
	a_drive_on: assert property (p_drive_on)
		else $error("outputs not driven with drive enable low");

	property p_drive_off;
		@(posedge CLOCK) disable iff (SRST)
		f_drv_n |=> (BUS_DRIVERS_OE == `NBGR_OE_OFF);
	endproperty
	a_drive_off: assert property (p_drive_off)
		else $error("outputs not released with drive enable high");

	property p_common_oe;
		@(posedge CLOCK) disable iff (SRST)
		(BUS_DRIVERS_OE == `NBGR_OE_OFF) || (BUS_DRIVERS_OE == ~`NBGR_OE_OFF);
	endproperty
	a_common_oe: assert property (p_common_oe)
		else $error("output enables split across bits");

	property p_drive_no_effect;
		@(posedge CLOCK) disable iff (SRST)
		($changed(f_drv_n) && f_clear_n && !clk_rise) |=> $stable(store_r);
	endproperty
	a_drive_no_effect: assert property (p_drive_no_effect)
		else $error("drive enable disturbed the store");

	property p_load_released;
		@(posedge CLOCK) disable iff (SRST)
		(f_drv_n && clk_rise && !f_gate_n && f_clear_n) |=> (store_r == $past(f_data));
	endproperty
	a_load_released: assert property (p_load_released)
		else $error("load failed while outputs released");

	property p_bits_apart;
		@(posedge CLOCK) disable iff (SRST)
		(clk_rise && !f_gate_n && f_clear_n && f_data[0] != f_data[8])
			|=> (BUS_DRIVERS[0] != BUS_DRIVERS[8]);
	endproperty
	a_bits_apart: assert property (p_bits_apart)
		else $error("storage bits not independent");

	// Clear keeps the word empty on every cycle that it is held
	property p_clear_hold;
		@(posedge CLOCK) disable iff (SRST)
		!f_clear_n |=> (store_r == `NBGR_STORE_RST) && (BUS_DRIVERS == `NBGR_STORE_RST);
	endproperty
	a_clear_hold: assert property (p_clear_hold)
		else $error("store not empty while clear held");

	property p_clear_released;
		@(posedge CLOCK) disable iff (SRST)
		(!f_clear_n && f_drv_n && (store_r != `NBGR_STORE_RST))
			|=> (store_r == `NBGR_STORE_RST);
	endproperty
	a_clear_released: assert property (p_clear_released)
		else $error("clear failed while outputs released");

	c_load: cover property (@(posedge CLOCK) disable iff (SRST)
		load_ok ##1 (BUS_DRIVERS != `NBGR_STORE_RST));
	c_clear: cover property (@(posedge CLOCK) disable iff (SRST)
		(BUS_DRIVERS != `NBGR_STORE_RST) ##1 !f_clear_n ##1 (BUS_DRIVERS == `NBGR_STORE_RST));
	c_gate_hold: cover property (@(posedge CLOCK) disable iff (SRST)
		clk_rise && f_gate_n && f_clear_n);
	c_load_released: cover property (@(posedge CLOCK) disable iff (SRST)
		load_ok && f_drv_n);
	c_clear_released: cover property (@(posedge CLOCK) disable iff (SRST)
		!f_clear_n && f_drv_n && (store_r != `NBGR_STORE_RST));

endmodule

`default_nettype wire

// File: nbgr_bus_model.sv
`timescale 1ns/10ps
`default_nettype none
module nbgr_bus_model
	import nbgr_pkg::*;
(
	input  wire nbgr_word_t drv,
	input  wire nbgr_word_t oe,
	output var  nbgr_word_t line
);
	// No keeper: a released line shows the inverse of the driver value,
	// so a check that trusts a floating bus cannot pass by accident
	always_comb line = (oe & drv) | (~oe & ~drv);
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin errors++; \
	$display("MISMATCH %s exp %h seen %h", n, e, s); end end
module tb_top
	import nbgr_pkg::*;
;
	logic       clk, srst, rclk, clear_n, gate_n, drv_n;
	nbgr_word_t din, dout, oe, line, exp_w;
	int         errors, n_tests, seed;
	nbgr_top nbgr_top_inst (.CLOCK(clk), .SRST(srst), .REGISTER_CLOCK(rclk),
		.REGISTER_CLEAR_N(clear_n), .CAPTURE_GATE_N(gate_n), .OUTPUT_DRIVE_N(drv_n),
		.PARALLEL_INPUTS(din), .BUS_DRIVERS(dout), .BUS_DRIVERS_OE(oe));
	nbgr_bus_model nbgr_bus_model_inst (.drv(dout), .oe(oe), .line(line));
	function automatic nbgr_word_t next_w(nbgr_word_t w, nbgr_word_t d, logic g, logic c);
		return !c ? 9'h000 : (!g ? d : w);
	endfunction
	task automatic wrap_up();
		$display("errors %0d tests %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// One register clock pulse, phases well above the pin filter
	task automatic op(nbgr_word_t d, logic g, logic c, logic e);
		@(negedge clk);
		din = d;
		gate_n = g;
		clear_n = c;
		drv_n = e;
		repeat (4) @(negedge clk);
		rclk = 1'b1;
		repeat (4) @(negedge clk);
		rclk = 1'b0;
		din = ~d;
		repeat (6) @(negedge clk);
		exp_w = next_w(exp_w, d, g, c);
		`CHK("store", exp_w, dout)
		`CHK("oe", e ? 9'h000 : 9'h1ff, oe)
		if (!e) `CHK("line", exp_w, line)
		else `CHK("released", ~exp_w, line)
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		#200us;
		errors++;
		wrap_up();
	end
	initial begin
		seed = 32'h361449ab;
		srst = 1'b1;
		rclk = 1'b0;
		clear_n = 1'b1;
		gate_n = 1'b1;
		drv_n = 1'b1;
		din = 9'h000;
		exp_w = 9'h000;
		errors = 0;
		n_tests = 0;
		repeat (10) @(negedge clk);
		srst = 1'b0;
		@(negedge clk);
		`CHK("rst", 9'h000, oe)
		op(9'h1ff, 1'b0, 1'b1, 1'b0);
		op(9'h0a5, 1'b1, 1'b1, 1'b0);
		op(9'h15a, 1'b0, 1'b0, 1'b0);
		op(9'h123, 1'b0, 1'b1, 1'b1);
		op(9'h0ff, 1'b0, 1'b0, 1'b1);
		op(9'h000, 1'b1, 1'b1, 1'b0);
		repeat (40)
			op(9'($random(seed)), 1'($random(seed)), 1'($random(seed)), 1'($random(seed)));
		wrap_up();
	end
endmodule
`default_nettype wire
